/* File: awd_pkg.sv */
// Shared constants and types for the waveform sequencer
package awd_pkg;
	// ----------------------------------------
	// Widths and sizes
	// ----------------------------------------
	localparam int CHANNELS = 2;
	localparam int SAMPLE_W = 16;
	localparam int ADDR_W = 15;
	localparam int MEM_DEPTH = 32400;
	localparam int WAVE_COUNT = 64;
	localparam int WAVE_W = 6;
	localparam int INTERVAL_W = 16;
	localparam int MARK_W = 7;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int QTR_PER_US = 4;
	localparam int QTR_NS = 250;
	localparam int INTERVAL_MIN_NS = 1250;
	localparam int START_PULSE_NS = 600;
	localparam int STEP_PULSE_NS = 350;
	// Interval register holds quarter-microsecond count minus one
	localparam logic [INTERVAL_W-1:0] INTERVAL_MIN =
		INTERVAL_W'(INTERVAL_MIN_NS / QTR_NS - 1);
	// Least widths round up to whole cycles
	localparam logic [MARK_W-1:0] START_CYC =
		MARK_W'((START_PULSE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [MARK_W-1:0] STEP_CYC =
		MARK_W'((STEP_PULSE_NS * CLK_MHZ + 999) / 1000);

	// ----------------------------------------
	// Reset defaults
	// ----------------------------------------
	localparam logic [WAVE_W-1:0] WAVE_RST = 6'h00;
	localparam logic [ADDR_W-1:0] ADDR_LAST = ADDR_W'(MEM_DEPTH - 1);

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		MARK_START,
		MARK_WAVE,
		MARK_STEP,
		MARK_HOLD
	} awd_mark_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ARMED,
		ST_PLAY
	} awd_state_t;
endpackage : awd_pkg

/* File: awd_mem_if.sv */
// Sample memory port bundle between sequencer and memory
`timescale 1ns/10ps
interface awd_mem_if;
	logic wr_en;
	logic [14:0] wr_addr;
	logic [15:0] wr_data;
	logic rd_en;
	logic [14:0] rd_addr;
	logic [15:0] rd_data;
	logic clr;
	logic busy;

	modport ctl (
		output wr_en, wr_addr, wr_data, rd_en, rd_addr, clr,
		input rd_data, busy
	);
	modport mem (
		input wr_en, wr_addr, wr_data, rd_en, rd_addr, clr,
		output rd_data, busy
	);
endinterface : awd_mem_if

/* File: awd_mem.sv */
// Per-channel sample memory with registered read and clear engine
`timescale 1ns/10ps
module awd_mem (
	// Clock and reset
	input logic clk,
	input logic rst_n,
	// Memory port
	awd_mem_if.mem m
);
	logic [15:0] store [0:awd_pkg::MEM_DEPTH-1];
	logic clearing;
	logic [awd_pkg::ADDR_W-1:0] clr_addr;

	// ----------------------------------------
	// Clear engine
	// ----------------------------------------
	// walk and zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clearing <= 1'b1;
			clr_addr <= 15'h0000;
		end else if (m.clr) begin
			clearing <= 1'b1;
			clr_addr <= 15'h0000;
		end else if (clearing) begin
			if (clr_addr == awd_pkg::ADDR_LAST) begin
				clearing <= 1'b0;
			end
			clr_addr <= clr_addr + 15'h0001;
		end
	end

	assign m.busy = clearing;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// Clearing owns the write port; host loads are held off by busy
	always_ff @(posedge clk) begin
		if (clearing) begin
			store[clr_addr] <= 16'h0000;
		end else if (m.wr_en) begin
			store[m.wr_addr] <= m.wr_data;
		end
		if (m.rd_en) begin
			m.rd_data <= store[m.rd_addr];
		end
	end
endmodule : awd_mem

/* File: awd_top.sv */
// Two-channel waveform sequencer: memory, pacing and marker output
// ----------------------------------------
// Overview of operation
// - Self-test zeroes every stored sample of each channel's memory.
// - Start-event marker mode gives one pulse of 0.4 to 0.8 us as a pass starts.
// - Per-waveform marker mode drives the marker low on the same edge as the first sample loads.
// - Per-step marker mode gives a short pulse of about 350 ns on each output step.
// - Held-high marker mode keeps the marker constantly high with no pulses.
// - With outside pacing chosen, a pass starts on a rising edge of the pacing input.
// - A reset command returns both channels to defaults before further commands.
// - Each channel has its own sample output, marker output and pacing input.
// - The step interval spans 1.25 us to 16.384 ms in 0.25 us steps.
// - Each memory holds 32,400 points split among up to 64 waveforms.
// - A channel either plays once or repeats continuously.
// - Stored data is lost on power-up, host reset or reset command.
// ----------------------------------------
`timescale 1ns/10ps
module awd_top (
	// Clock and reset
	input logic clk,
	input logic rst_n,
	// Commands
	input logic cmd_reset,
	input logic cmd_selftest,
	// Sample loading
	input logic ld_we,
	input logic ld_chan,
	input logic [14:0] ld_addr,
	input logic [15:0] ld_data,
	// Waveform table
	input logic tbl_we,
	input logic tbl_chan,
	input logic [5:0] tbl_idx,
	input logic [14:0] tbl_start,
	input logic [14:0] tbl_len,
	// Channel configuration
	input logic cfg_we,
	input logic cfg_chan,
	input logic [5:0] cfg_wave,
	input logic cfg_outside,
	input logic cfg_rearm,
	input awd_pkg::awd_mark_t cfg_mark,
	input logic [15:0] cfg_interval,
	input logic [1:0] arm,
	// Pins
	input logic [1:0] outside_pacing_input,
	output logic [1:0][15:0] dac_data,
	output logic [1:0] dac_load,
	output logic [1:0] marker_output,
	// Status
	output logic [1:0] running,
	output logic busy
);
	logic rst_s1;
	logic rst_i_n;
	logic [1:0] mem_busy;
	logic [1:0] pace_s1;
	logic [1:0] pace_s2;
	logic [1:0] pace_s3;

	// ----------------------------------------
	// Reset release and pin synchronisers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1 <= 1'b0;
			rst_i_n <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_i_n <= rst_s1;
		end
	end

	// Pacing pins are asynchronous; third stage only feeds the edge detect
	always_ff @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			pace_s1 <= 2'h0;
			pace_s2 <= 2'h0;
			pace_s3 <= 2'h0;
		end else begin
			pace_s1 <= outside_pacing_input;
			pace_s2 <= pace_s1;
			pace_s3 <= pace_s2;
		end
	end

	always_ff @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			busy <= 1'b1;
		end else begin
			busy <= |mem_busy;
		end
	end

	// ----------------------------------------
	// Channels
	// ----------------------------------------
	// independent channels
	for (genvar c = 0; c < awd_pkg::CHANNELS; c++) begin : g_ch
		awd_mem_if mi ();
		logic [14:0] tstart [0:awd_pkg::WAVE_COUNT-1];
		logic [14:0] tlen [0:awd_pkg::WAVE_COUNT-1];
		logic [5:0] wave;
		logic outside;
		logic rearm;
		awd_pkg::awd_mark_t mmode;
		logic [15:0] interval;
		awd_pkg::awd_state_t state;
		logic [14:0] addr;
		logic [14:0] remain;
		logic [15:0] qcnt;
		logic rd_pend;
		logic [6:0] mcnt;
		logic wf_mark;
		logic go;
		logic step;
		logic issue;
		logic sel;
		logic [6:0] qacc;
		logic qtick;

		awd_mem u_mem (
			.clk(clk),
			.rst_n(rst_i_n),
			.m(mi.ctl)
		);

		assign sel = !mi.busy && !cmd_reset;
		assign go = state == awd_pkg::ST_ARMED &&
			(!outside || (pace_s2[c] && !pace_s3[c]));
		assign step = state == awd_pkg::ST_PLAY && qtick && qcnt == interval;
		assign issue = (go && tlen[wave] != 15'h0000) || (step && remain != 15'h0000);
		assign mem_busy[c] = mi.busy;
		assign mi.clr = cmd_selftest || cmd_reset;
		assign mi.wr_en = ld_we && ld_chan == 1'(c) && sel;
		assign mi.wr_addr = ld_addr;
		assign mi.wr_data = ld_data;
		assign mi.rd_en = issue;
		assign mi.rd_addr = go ? tstart[wave] : addr;

		// exact 0.25 us tick per channel
		// Phase restarts at go, counting that edge, so the first step is a whole interval
		always_ff @(posedge clk or negedge rst_i_n) begin
			if (!rst_i_n) begin
				qacc <= 7'h00;
				qtick <= 1'b0;
			end else if (go) begin
				qacc <= 7'(awd_pkg::QTR_PER_US);
				qtick <= 1'b0;
			end else if ({1'b0, qacc} + 8'(awd_pkg::QTR_PER_US) >= 8'(awd_pkg::CLK_MHZ)) begin
				qacc <= qacc + 7'(awd_pkg::QTR_PER_US) - 7'(awd_pkg::CLK_MHZ);
				qtick <= 1'b1;
			end else begin
				qacc <= qacc + 7'(awd_pkg::QTR_PER_US);
				qtick <= 1'b0;
			end
		end

		always_ff @(posedge clk) begin
			if (tbl_we && tbl_chan == 1'(c) && sel) begin
				tstart[tbl_idx] <= tbl_start;
				tlen[tbl_idx] <= tbl_len;
			end
		end

		always_ff @(posedge clk or negedge rst_i_n) begin
			if (!rst_i_n) begin
				wave <= awd_pkg::WAVE_RST;
				outside <= 1'b0;
				rearm <= 1'b0;
				mmode <= awd_pkg::MARK_START;
				interval <= awd_pkg::INTERVAL_MIN;
			end else if (cmd_reset) begin
				wave <= awd_pkg::WAVE_RST;
				outside <= 1'b0;
				rearm <= 1'b0;
				mmode <= awd_pkg::MARK_START;
				interval <= awd_pkg::INTERVAL_MIN;
			end else if (cfg_we && cfg_chan == 1'(c) && sel) begin
				wave <= cfg_wave;
				outside <= cfg_outside;
				rearm <= cfg_rearm;
				mmode <= cfg_mark;
				interval <= cfg_interval < awd_pkg::INTERVAL_MIN ?
					awd_pkg::INTERVAL_MIN : cfg_interval;
			end
		end

		always_ff @(posedge clk or negedge rst_i_n) begin
			if (!rst_i_n) begin
				state <= awd_pkg::ST_IDLE;
				addr <= 15'h0000;
				remain <= 15'h0000;
				qcnt <= 16'h0000;
			end else if (cmd_reset || cmd_selftest || mi.busy) begin
				state <= awd_pkg::ST_IDLE;
				qcnt <= 16'h0000;
			end else begin
				unique case (state)
					awd_pkg::ST_IDLE: begin
						if (arm[c]) begin
							state <= awd_pkg::ST_ARMED;
						end
					end
					awd_pkg::ST_ARMED: begin
						if (go) begin
							state <= awd_pkg::ST_PLAY;
							addr <= tstart[wave] + 15'h0001;
							remain <= tlen[wave] == 15'h0000 ? 15'h0000 :
								tlen[wave] - 15'h0001;
							qcnt <= 16'h0000;
						end
					end
					awd_pkg::ST_PLAY: begin
						if (qtick) begin
							qcnt <= step ? 16'h0000 : qcnt + 16'h0001;
						end
						if (step && remain != 15'h0000) begin
							addr <= addr + 15'h0001;
							remain <= remain - 15'h0001;
						end else if (step) begin
							state <= rearm ? awd_pkg::ST_ARMED : awd_pkg::ST_IDLE;
						end
					end
				endcase
			end
		end

		// Sample out one cycle after the read
		always_ff @(posedge clk or negedge rst_i_n) begin
			if (!rst_i_n) begin
				rd_pend <= 1'b0;
				dac_data[c] <= 16'h0000;
				dac_load[c] <= 1'b0;
				running[c] <= 1'b0;
			end else begin
				rd_pend <= issue;
				dac_load[c] <= rd_pend;
				if (rd_pend) begin
					dac_data[c] <= mi.rd_data;
				end
				running[c] <= state != awd_pkg::ST_IDLE;
			end
		end

		// Marker timing
		always_ff @(posedge clk or negedge rst_i_n) begin
			if (!rst_i_n) begin
				mcnt <= 7'h00;
				wf_mark <= 1'b1;
			// no pulse left over from before the reset
			end else if (cmd_reset) begin
				mcnt <= 7'h00;
				wf_mark <= 1'b1;
			end else begin
				if (go && mmode == awd_pkg::MARK_START) begin
					mcnt <= awd_pkg::START_CYC;
				end else if (issue && mmode == awd_pkg::MARK_STEP) begin
					mcnt <= awd_pkg::STEP_CYC;
				end else if (mcnt != 7'h00) begin
					mcnt <= mcnt - 7'h01;
				end
				// low from start until last sample
				if (go) begin
					wf_mark <= 1'b0;
				end else if (issue && remain == 15'h0001) begin
					wf_mark <= 1'b1;
				end else if (state == awd_pkg::ST_IDLE) begin
					wf_mark <= 1'b1;
				end
			end
		end

		always_ff @(posedge clk or negedge rst_i_n) begin
			if (!rst_i_n) begin
				marker_output[c] <= 1'b0;
			end else begin
				unique case (mmode)
					awd_pkg::MARK_WAVE: marker_output[c] <= wf_mark;
					awd_pkg::MARK_HOLD: marker_output[c] <= 1'b1;
					default: marker_output[c] <= mcnt != 7'h00;
				endcase
			end
		end
	end
endmodule : awd_top

/* File: awd_checker.sv */
// Port assertions for the waveform sequencer top
`timescale 1ns/10ps
module awd_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Watched ports
	input wire logic cmd_reset,
	input wire logic cmd_selftest,
	input wire logic cfg_we,
	input wire logic cfg_chan,
	input awd_pkg::awd_mark_t cfg_mark,
	input wire logic [1:0] arm,
	input wire logic [1:0] dac_load,
	input wire logic [1:0] marker_output,
	input wire logic [1:0] running,
	input wire logic busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// Channel 0 mode and pulse length
	// ----------------------------------------
	awd_pkg::awd_mark_t mode;
	awd_pkg::awd_mark_t rmode;
	logic m_q;
	logic [15:0] hi;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode <= awd_pkg::MARK_START;
		end else if (cmd_reset) begin
			mode <= awd_pkg::MARK_START;
		end else if (cfg_we && !cfg_chan && !busy) begin
			mode <= cfg_mark;
		end
	end
	// Mode latched at the rising edge, so a mode change never blames an old pulse
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			m_q <= 1'b0;
			rmode <= awd_pkg::MARK_START;
			hi <= 16'h0000;
		end else begin
			m_q <= marker_output[0];
			hi <= marker_output[0] ? hi + 16'h0001 : 16'h0000;
			if (marker_output[0] && !m_q) begin
				rmode <= mode;
			end
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	sequence s_pass_low;
		##[1:4] !marker_output[0];
	endsequence
	sequence s_clear;
		##[1:3] busy;
	endsequence
	a_start_width: assert property ($fell(marker_output[0]) && rmode == awd_pkg::MARK_START
		|-> hi >= 16'h0032 && hi <= 16'h0064) else $error("start pulse width wrong");
	a_step_width: assert property ($fell(marker_output[0]) && rmode == awd_pkg::MARK_STEP
		|-> hi == 16'(awd_pkg::STEP_CYC)) else $error("step pulse width wrong");
	a_wave_low: assert property (mode == awd_pkg::MARK_WAVE && $rose(running[0])
		|-> s_pass_low) else $error("wave marker not low");
	a_hold_high: assert property (mode == awd_pkg::MARK_HOLD && running[0]
		|-> marker_output[0]) else $error("hold marker dropped");
	a_load_single: assert property (dac_load[0] |=> !dac_load[0]) else $error("load too long");
	a_arm_runs: assert property (arm[0] && !running[0] && !busy
		|-> ##[1:2] running[0]) else $error("arm not taken");
	a_clear_start: assert property (cmd_selftest && !busy |-> s_clear) else $error("no clear");
	a_clear_stops: assert property ($rose(busy) |-> ##[0:3] running == 2'b00)
		else $error("channel runs in clear");
	a_clear_quiet: assert property (busy |-> dac_load == 2'b00) else $error("load in clear");
	a_reset_quiet: assert property (cmd_reset |=> ##1 marker_output == 2'b00)
		else $error("marker after reset");
endmodule : awd_checker

bind awd_top awd_checker i_awd_checker (.clk(clk), .rst_n(rst_n), .cmd_reset(cmd_reset),
	.cmd_selftest(cmd_selftest), .cfg_we(cfg_we), .cfg_chan(cfg_chan), .cfg_mark(cfg_mark),
	.arm(arm), .dac_load(dac_load), .marker_output(marker_output), .running(running),
	.busy(busy));

/* File: awd_host.sv */
// Mainframe controller model that loads data and issues commands
`timescale 1ns/10ps
module awd_host (
	// Clock
	input wire logic clk,
	// Commands
	output logic cmd_reset,
	output logic cmd_selftest,
	output logic ld_we,
	output logic ld_chan,
	output logic [14:0] ld_addr,
	output logic [15:0] ld_data,
	output logic tbl_we,
	output logic tbl_chan,
	output logic [5:0] tbl_idx,
	output logic [14:0] tbl_start,
	output logic [14:0] tbl_len,
	output logic cfg_we,
	output logic cfg_chan,
	output logic [5:0] cfg_wave,
	output logic cfg_outside,
	output logic cfg_rearm,
	output awd_pkg::awd_mark_t cfg_mark,
	output logic [15:0] cfg_interval,
	output logic [1:0] arm
);
	initial begin
		{cmd_reset, cmd_selftest, ld_we, ld_chan, ld_addr, ld_data} = '0;
		{tbl_we, tbl_chan, tbl_idx, tbl_start, tbl_len} = '0;
		{cfg_we, cfg_chan, cfg_wave, cfg_outside, cfg_rearm, cfg_interval, arm} = '0;
		cfg_mark = awd_pkg::MARK_START;
	end
	// Every strobe is held one edge, then one edge passes idle; callers enter just after an edge
	task automatic put(input logic c, input logic [14:0] a, input logic [15:0] d);
		{ld_we, ld_chan, ld_addr, ld_data} = {1'b1, c, a, d};
		@(posedge clk);
		#1 ld_we = 1'b0;
		@(posedge clk) #1;
	endtask : put
	task automatic tbl(input logic c, input logic [5:0] i, input logic [14:0] s, input logic [14:0] n);
		{tbl_we, tbl_chan, tbl_idx, tbl_start, tbl_len} = {1'b1, c, i, s, n};
		@(posedge clk);
		#1 tbl_we = 1'b0;
		@(posedge clk) #1;
	endtask : tbl
	task automatic cfg(input logic c, input logic [5:0] w, input logic o, input logic r,
		input awd_pkg::awd_mark_t m);
		{cfg_we, cfg_chan, cfg_wave, cfg_outside, cfg_rearm} = {1'b1, c, w, o, r};
		cfg_mark = m;
		cfg_interval = 16'h0004;
		@(posedge clk);
		#1 cfg_we = 1'b0;
		@(posedge clk) #1;
	endtask : cfg
	task automatic go(input logic [1:0] a, input logic t);
		arm = a;
		cmd_selftest = t;
		@(posedge clk);
		#1 {arm, cmd_selftest} = '0;
		@(posedge clk) #1;
	endtask : go
	task automatic cmdrst();
		cmd_reset = 1'b1;
		@(posedge clk);
		#1 cmd_reset = 1'b0;
		@(posedge clk) #1;
	endtask : cmdrst
endmodule : awd_host

/* File: awd_top_bench.sv */
// Self-checking bench for the two-channel waveform sequencer
`timescale 1ns/10ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_total++; \
	$display("mismatch %s expected %h seen %h", n, e, s); end end
module awd_top_bench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] pin = 2'b00;
	logic [1:0][15:0] dac_data;
	logic [1:0] dac_load, marker_output, running;
	logic busy, cmd_reset, cmd_selftest, ld_we, ld_chan, tbl_we, tbl_chan, cfg_we, cfg_chan;
	logic cfg_outside, cfg_rearm;
	logic [14:0] ld_addr, tbl_start, tbl_len;
	logic [15:0] ld_data, cfg_interval, rnd = 16'h005c;
	logic [5:0] tbl_idx, cfg_wave;
	logic [1:0] arm;
	awd_pkg::awd_mark_t cfg_mark;
	logic [15:0] s [3];
	int err_total = 0, checked = 0, cyc = 0, t0;
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			err_total++;
			report_and_stop();
		end
	end
	awd_host i_awd_host (.*);
	awd_top i_awd_top (.clk(clk), .rst_n(rst_n), .cmd_reset(cmd_reset), .cmd_selftest(cmd_selftest),
		.ld_we(ld_we), .ld_chan(ld_chan), .ld_addr(ld_addr), .ld_data(ld_data), .tbl_we(tbl_we),
		.tbl_chan(tbl_chan), .tbl_idx(tbl_idx), .tbl_start(tbl_start), .tbl_len(tbl_len),
		.cfg_we(cfg_we), .cfg_chan(cfg_chan), .cfg_wave(cfg_wave), .cfg_outside(cfg_outside),
		.cfg_rearm(cfg_rearm), .cfg_mark(cfg_mark), .cfg_interval(cfg_interval), .arm(arm),
		.outside_pacing_input(pin), .dac_data(dac_data), .dac_load(dac_load),
		.marker_output(marker_output), .running(running), .busy(busy));
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr
	// Bounded waits for a load on a channel, or for no clear and both channels idle
	task automatic wait_load(input int c, input int lim);
		for (int i = 0; i < lim && dac_load[c] !== 1'b1; i++) @(posedge clk) #1;
	endtask : wait_load
	task automatic idle_wait(input int lim);
		for (int i = 0; i < lim && (busy !== 1'b0 || running !== 2'b00); i++) @(posedge clk) #1;
	endtask : idle_wait
	// one sample per interval, 5 quarter-us apart
	task automatic pass0(input int n);
		wait_load(0, 40);
		t0 = cyc;
		for (int k = 0; k < n; k++) begin
			if (k > 0) wait_load(0, 200);
			if (k > 0) `CHK("gap", 1'b1, (cyc - t0) inside {156, 157})
			t0 = cyc;
			`CHK("ch0 data", s[k % 3], dac_data[0])
			@(posedge clk) #1;
		end
	endtask : pass0
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		idle_wait(33000);
		for (int i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			s[i] = rnd;
			i_awd_host.put(1'b0, 15'(i), s[i]);
		end
		i_awd_host.tbl(1'b0, 6'h00, 15'h0000, 15'h0003);
		// Step, hold and per-waveform marker modes, one pass each
		for (int m = 2; m < 5; m++) begin
			i_awd_host.cfg(1'b0, 6'h00, 1'b0, 1'b0, awd_pkg::awd_mark_t'(m[1:0] ^ {1'b0, m[2]}));
			i_awd_host.go(2'b01, 1'b0);
			wait_load(0, 40);
			if (m == 3) `CHK("hold", 1'b1, marker_output[0])
			if (m == 4) `CHK("wave low", 1'b0, marker_output[0])
			pass0(3);
			idle_wait(400);
			`CHK("once stop", 1'b0, running[0])
			$display("test mode %0d done", m);
		end
		// Outside pacing on channel 1 waits for the pin
		i_awd_host.put(1'b1, 15'h7e8f, rnd);
		i_awd_host.tbl(1'b1, 6'h3f, 15'h7e8f, 15'h0001);
		i_awd_host.cfg(1'b1, 6'h3f, 1'b1, 1'b0, awd_pkg::MARK_START);
		i_awd_host.go(2'b10, 1'b0);
		wait_load(1, 60);
		`CHK("no pace", 1'b0, dac_load[1])
		pin = 2'b10;
		wait_load(1, 12);
		`CHK("paced", 1'b1, dac_load[1])
		`CHK("ch1 data", rnd, dac_data[1])
		pin = 2'b00;
		$display("test pacing done");
		// Repeating start-mode pass, stopped by self-test
		i_awd_host.cfg(1'b0, 6'h00, 1'b0, 1'b1, awd_pkg::MARK_START);
		i_awd_host.go(2'b01, 1'b0);
		pass0(5);
		`CHK("rearm", 1'b1, running[0])
		i_awd_host.go(2'b00, 1'b1);
		idle_wait(33000);
		`CHK("stopped", 2'b00, running)
		i_awd_host.tbl(1'b0, 6'h00, 15'h0001, 15'h0001);
		i_awd_host.cfg(1'b0, 6'h00, 1'b0, 1'b0, awd_pkg::MARK_START);
		i_awd_host.go(2'b01, 1'b0);
		wait_load(0, 40);
		`CHK("cleared", 16'h0000, dac_data[0])
		$display("test selftest done");
		// Reset command restores defaults and refuses configuration while clearing
		idle_wait(400);
		i_awd_host.cfg(1'b0, 6'h00, 1'b0, 1'b0, awd_pkg::MARK_HOLD);
		`CHK("hold set", 1'b1, marker_output[0])
		i_awd_host.cmdrst();
		`CHK("reset mark", 1'b0, marker_output[0])
		`CHK("reset busy", 1'b1, busy)
		i_awd_host.cfg(1'b0, 6'h00, 1'b0, 1'b0, awd_pkg::MARK_HOLD);
		`CHK("cfg refused", 1'b0, marker_output[0])
		$display("test reset done");
		report_and_stop();
	end
endmodule : awd_top_bench
